// [logic/eft_tuning_top.sv]
`timescale 1ns/10ps
// Contract
// - Outside exact mode the accumulator uses a fixed 2^24 binary modulus.
// - Exact mode keeps the full 24-bit accumulator and still lands exactly.
// - Exact step count register holds steps per integer interval, below 2^14.
// - Exact mode may be set per frequency or once for a common gcd.
// - Channel mode: integer and step count once, then only fractional writes.
// - Integer field is 19 bits, fractional 24 bits, both unsigned binary.
module eft_tuning_top
   import eft_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Register port from the serial interface
   input wire logic [4:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [23:0] rd_data_reg,
   output logic rd_valid_reg,
   // Modulator configuration
   input wire logic mod_enable,
   input wire logic mod_bypass,
   // Status and divider output
   output logic pending_reg,
   output logic [19:0] div_ratio
);
   logic [18:0] int_stage_reg;
   logic [13:0] step_stage_reg;
   logic [18:0] int_active_reg;
   logic [23:0] frac_active_reg;
   logic [13:0] step_active_reg;
   logic [23:0] rd_data_next;
   logic pending_next;

   wire hit_int = reg_addr == EFT_OFS_INTEGER_DIVIDER;
   wire hit_frac = reg_addr == EFT_OFS_FRACTIONAL_WORD;
   wire hit_step = reg_addr == EFT_OFS_EXACT_STEP_COUNT;
   wire wr_int = ce && reg_wr && hit_int;
   wire wr_step = ce && reg_wr && hit_step;
   // Fractional write is the commit point; the other two only stage
   wire wr_frac = ce && reg_wr && hit_frac;

   // Unmapped reads return zero; narrow fields read zero above their width
   assign rd_data_next = hit_int ? {5'h00, int_stage_reg} :
                         hit_frac ? frac_active_reg :
                         hit_step ? {10'h000, step_stage_reg} :
                         24'h000000;
   // A staging write in the same cycle as the commit is carried by that commit
   assign pending_next = wr_frac ? 1'b0 : (pending_reg || wr_int || wr_step);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         int_stage_reg <= EFT_INT_RESET;
         step_stage_reg <= EFT_STEP_RESET;
      end else begin
         if (wr_int) begin
            int_stage_reg <= reg_wdata[18:0];
         end
         if (wr_step) begin
            step_stage_reg <= reg_wdata[13:0];
         end
      end
   end

   // Channel retunes touch only the fraction, so integer and steps stay as committed
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         int_active_reg <= EFT_INT_RESET;
         frac_active_reg <= EFT_FRAC_RESET;
         step_active_reg <= EFT_STEP_RESET;
      end else if (wr_frac) begin
         int_active_reg <= wr_int ? reg_wdata[18:0] : int_stage_reg;
         frac_active_reg <= reg_wdata;
         step_active_reg <= wr_step ? reg_wdata[13:0] : step_stage_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_data_reg <= 24'h000000;
         rd_valid_reg <= 1'b0;
         pending_reg <= 1'b0;
      end else if (ce) begin
         rd_valid_reg <= reg_rd;
         pending_reg <= pending_next;
         if (reg_rd) begin
            rd_data_reg <= rd_data_next;
         end
      end
   end

   eft_modulator u_mod (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .mod_enable(mod_enable),
      .mod_bypass(mod_bypass),
      .load(wr_frac),
      .int_val(int_active_reg),
      .frac_val(frac_active_reg),
      .step_val(step_active_reg),
      .div_ratio_reg(div_ratio)
   );

   chk_commit_together: assert property (@(posedge clk) disable iff (!rst_b)
      wr_frac && !reg_rd |=> frac_active_reg == $past(reg_wdata)
         && int_active_reg == $past(int_stage_reg) && step_active_reg == $past(step_stage_reg))
      else $error("settings not applied together on fraction write");

   chk_stage_held: assert property (@(posedge clk) disable iff (!rst_b)
      wr_int |=> $stable(int_active_reg) && pending_reg)
      else $error("integer write took effect before commit");

   chk_channel_retune: assert property (@(posedge clk) disable iff (!rst_b)
      wr_frac && !pending_reg |=> $stable(int_active_reg) && $stable(step_active_reg))
      else $error("fraction-only retune moved integer or steps");

   chk_step_readback: assert property (@(posedge clk) disable iff (!rst_b)
      wr_step ##1 !reg_wr ##1 ce && reg_rd && hit_step && !reg_wr
         |=> rd_valid_reg && rd_data_reg == {10'h000, $past(reg_wdata[13:0], 3)})
      else $error("step count readback wrong");

   chk_int_width: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_rd && hit_int |=> rd_data_reg[23:19] == 5'h00 && rd_data_reg[18:0] == $past(int_stage_reg))
      else $error("integer field width wrong on read");

   // Staged and active copies agree whenever nothing is pending, so a fraction-only retune is safe
   chk_staged_match: assert property (@(posedge clk) disable iff (!rst_b)
      !pending_reg |-> int_stage_reg == int_active_reg && step_stage_reg == step_active_reg)
      else $error("staged and active settings differ with nothing pending");

   chk_pending_clear: assert property (@(posedge clk) disable iff (!rst_b)
      wr_frac |=> !pending_reg)
      else $error("pending flag not cleared by commit");

   chk_pending_hold: assert property (@(posedge clk) disable iff (!rst_b)
      pending_reg && !wr_frac |=> pending_reg)
      else $error("pending flag dropped without a commit");

   chk_step_staged: assert property (@(posedge clk) disable iff (!rst_b)
      wr_step |=> $stable(step_active_reg) && pending_reg)
      else $error("step count write took effect before commit");

   chk_int_stage_write: assert property (@(posedge clk) disable iff (!rst_b)
      wr_int |=> int_stage_reg == $past(reg_wdata[18:0]))
      else $error("integer staging write lost");

   chk_step_stage_write: assert property (@(posedge clk) disable iff (!rst_b)
      wr_step |=> step_stage_reg == $past(reg_wdata[13:0]))
      else $error("step count staging write lost");

   chk_frac_applied: assert property (@(posedge clk) disable iff (!rst_b)
      wr_frac |=> frac_active_reg == $past(reg_wdata))
      else $error("fraction write not applied");

   // Active settings only move on a commit, never on their own
   chk_active_held: assert property (@(posedge clk) disable iff (!rst_b)
      !wr_frac |=> $stable(int_active_reg) && $stable(frac_active_reg) && $stable(step_active_reg))
      else $error("active settings moved without a commit");

   chk_frozen_state: assert property (@(posedge clk) disable iff (!rst_b)
      !ce |=> $stable(rd_data_reg) && $stable(rd_valid_reg) && $stable(pending_reg)
         && $stable(int_stage_reg) && $stable(step_stage_reg))
      else $error("state changed while clock enable low");

   chk_read_valid: assert property (@(posedge clk) disable iff (!rst_b)
      ce |=> rd_valid_reg == $past(reg_rd))
      else $error("read valid does not follow read strobe");

   chk_read_hold: assert property (@(posedge clk) disable iff (!rst_b)
      ce && !reg_rd |=> $stable(rd_data_reg))
      else $error("read data changed without a read");

   chk_frac_readback: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_rd && hit_frac |=> rd_data_reg == $past(frac_active_reg))
      else $error("fraction readback wrong");

   chk_step_width: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_rd && hit_step |=> rd_data_reg[23:14] == 10'h000)
      else $error("step count reads bits above its width");

   // Unmapped indices neither answer with data nor disturb any setting
   chk_unmapped_read: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_rd && !hit_int && !hit_frac && !hit_step |=> rd_data_reg == 24'h000000)
      else $error("unmapped read returned data");

   chk_unmapped_write: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_wr && !hit_int && !hit_frac && !hit_step |=> $stable(int_stage_reg)
         && $stable(step_stage_reg) && $stable(frac_active_reg) && $stable(pending_reg))
      else $error("unmapped write changed a setting");

   chk_read_passive: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_rd && !reg_wr |=> $stable(pending_reg) && $stable(int_active_reg)
         && $stable(frac_active_reg))
      else $error("read disturbed the settings");

   // Bypass must show a freshly committed integer on the ratio registered one cycle after the commit
   chk_bypass_commit: assert property (@(posedge clk) disable iff (!rst_b)
      wr_frac ##1 ce && (!mod_enable || mod_bypass) |=> div_ratio == {1'b0, $past(int_active_reg)})
      else $error("committed integer not used in bypass");

   // The modulator may only nudge the integer ratio by one either way
   chk_ratio_range: assert property (@(posedge clk) disable iff (!rst_b)
      ce |=> div_ratio == {1'b0, $past(int_active_reg)}
         || div_ratio == 20'({1'b0, $past(int_active_reg)} + 20'h00001)
         || div_ratio == 20'({1'b0, $past(int_active_reg)} - 20'h00001))
      else $error("divider ratio strayed from the integer setting");

   // Without the exact correction nothing is ever subtracted, so no borrow can appear
   chk_binary_no_borrow: assert property (@(posedge clk) disable iff (!rst_b)
      ce && step_active_reg == EFT_STEP_RESET |=> div_ratio >= {1'b0, $past(int_active_reg)})
      else $error("binary mode divider ratio went below integer");
endmodule

// [common/eft_pkg.sv]
package eft_pkg;
   // Register indices on the serial register port
   localparam logic [4:0] EFT_OFS_INTEGER_DIVIDER = 5'h03;
   localparam logic [4:0] EFT_OFS_FRACTIONAL_WORD = 5'h04;
   localparam logic [4:0] EFT_OFS_EXACT_STEP_COUNT = 5'h0C;
   // Field widths
   localparam int EFT_INT_BITS = 19;
   localparam int EFT_FRAC_BITS = 24;
   localparam int EFT_STEP_BITS = 14;
   localparam int EFT_DATA_BITS = 24;
   localparam int EFT_DIV_BITS = 20;
   // Values after reset
   localparam logic [18:0] EFT_INT_RESET = 19'h00000;
   localparam logic [23:0] EFT_FRAC_RESET = 24'h000000;
   localparam logic [13:0] EFT_STEP_RESET = 14'h0000;
   localparam logic [23:0] EFT_ACC_RESET = 24'h000000;
   localparam logic [13:0] EFT_PHASE_RESET = 14'h0000;
   localparam logic [19:0] EFT_DIV_RESET = 20'h00000;
endpackage

// [logic/eft_modulator.sv]
`timescale 1ns/10ps
module eft_modulator
   import eft_pkg::*;
(
   // Clock and control
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic mod_enable,
   input wire logic mod_bypass,
   // Commit strobe and active settings
   input wire logic load,
   input wire logic [18:0] int_val,
   input wire logic [23:0] frac_val,
   input wire logic [13:0] step_val,
   // Divider ratio to the feedback divider
   output logic [19:0] div_ratio_reg
);
   logic [23:0] acc_reg;
   logic [23:0] acc_next;
   logic [13:0] phase_reg;
   logic [13:0] phase_next;
   logic [19:0] div_ratio_next;

   wire run = mod_enable && !mod_bypass;
   wire exact = step_val != EFT_STEP_RESET;
   wire wrap = exact && (phase_reg == 14'(step_val - 14'h0001));
   // Residue of frac*steps over 2^24 is the excess that ceil() added over one full step period
   wire [37:0] product = {14'h0000, frac_val} * {24'h000000, step_val};
   wire [23:0] corr = wrap ? product[23:0] : 24'h000000;
   wire [25:0] sum = {2'b00, acc_reg} + {2'b00, frac_val} - {2'b00, corr};
   wire carry = (sum[25:24] == 2'b01);
   wire borrow = sum[25];

   // Accumulator always wraps at the full 24-bit modulus; exact mode only trims once per step period
   assign acc_next = run ? sum[23:0] : EFT_ACC_RESET;
   assign phase_next = (!run || load || !exact || wrap) ? EFT_PHASE_RESET : 14'(phase_reg + 14'h0001);
   assign div_ratio_next = run ? 20'({1'b0, int_val} + {19'h00000, carry} - {19'h00000, borrow})
                               : {1'b0, int_val};

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         acc_reg <= EFT_ACC_RESET;
         phase_reg <= EFT_PHASE_RESET;
         div_ratio_reg <= EFT_DIV_RESET;
      end else if (ce) begin
         acc_reg <= acc_next;
         phase_reg <= phase_next;
         div_ratio_reg <= div_ratio_next;
      end
   end

   chk_binary_modulus: assert property (@(posedge clk) disable iff (!rst_b)
      ce && run && !exact |=> acc_reg == 24'($past(acc_reg) + $past(frac_val)))
      else $error("binary modulus accumulation wrong");

   chk_exact_period: assert property (@(posedge clk) disable iff (!rst_b)
      ce && run && wrap && !load ##1 ce && run && exact && !load && !wrap && $stable(step_val)
         |=> phase_reg == 14'h0001)
      else $error("exact step period did not restart");

   chk_bypass_integer: assert property (@(posedge clk) disable iff (!rst_b)
      ce && !run |=> div_ratio_reg == {1'b0, $past(int_val)} && acc_reg == EFT_ACC_RESET)
      else $error("bypass does not pass the integer ratio");
endmodule

// [test/test_eft_tuning_top.sv]
`timescale 1ns/10ps
module test_eft_tuning_top;
   import eft_pkg::*;
   logic clk, rst_b, ce, reg_wr, reg_rd, mod_enable, mod_bypass;
   logic [4:0] reg_addr;
   logic [23:0] reg_wdata, rd_data_reg;
   logic rd_valid_reg, pending_reg;
   logic [19:0] div_ratio;
   logic [31:0] acc;
   int n_mismatch, total_checks;
   typedef struct {logic [4:0] a; logic [23:0] d; logic [23:0] e;} eft_row_type;
   eft_row_type rows [7];
   eft_tuning_top u_eft_tuning_top (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .rd_data_reg(rd_data_reg),
      .rd_valid_reg(rd_valid_reg), .mod_enable(mod_enable), .mod_bypass(mod_bypass),
      .pending_reg(pending_reg), .div_ratio(div_ratio));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [4:0] a, input logic [23:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(32'(rd_valid_reg), 32'h1, "read valid");
      chk(32'(rd_data_reg), 32'(e), "read data");
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Sums ratios so the long-run average is checked exactly, whatever the sequence order
   task automatic sum_div(input int n);
      acc = 32'h0;
      repeat (n) begin
         @(posedge clk);
         #1;
         acc = acc + 32'(div_ratio);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      rst_b = 1'b0; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 5'h00;
      reg_wdata = 24'h000000; mod_enable = 1'b1; mod_bypass = 1'b0;
      rows = '{'{5'h03, 24'hFFFFFF, 24'h07FFFF}, '{5'h0C, 24'hFFFFFF, 24'h003FFF},
               '{5'h04, 24'hFFFFFF, 24'hFFFFFF}, '{5'h05, 24'h123456, 24'h000000},
               '{5'h03, 24'h00002D, 24'h00002D}, '{5'h0C, 24'h000C00, 24'h000C00},
               '{5'h04, 24'h93EAAB, 24'h93EAAB}};
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      chk(32'(div_ratio), 32'h0, "div after reset");
      chk(32'(pending_reg), 32'h0, "pending after reset");
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      $display("test rows done");
      cycles(8);
      sum_div(3072);
      chk(acc, 32'd140015, "exact period sum");
      sum_div(3072);
      chk(acc, 32'd140015, "second exact period");
      $display("test exact done");
      // Channel one of the same interval: only the fraction is rewritten
      wr(5'h04, 24'h938000);
      chk(32'(pending_reg), 32'h0, "retune not pending");
      cycles(4);
      sum_div(3072);
      chk(acc, 32'd140010, "channel one period");
      rd(5'h03, 24'h00002D);
      $display("test channel done");
      wr(5'h0C, 24'h000000);
      wr(5'h04, 24'h800000);
      cycles(4);
      sum_div(16);
      chk(acc, 32'd728, "binary half step");
      $display("test modulus done");
      @(posedge clk);
      mod_bypass <= 1'b1;
      wr(5'h03, 24'h000030);
      chk(32'(pending_reg), 32'h1, "staged pending");
      cycles(3);
      chk(32'(div_ratio), 32'h2D, "old integer kept");
      wr(5'h04, 24'h800000);
      cycles(3);
      chk(32'(pending_reg), 32'h0, "committed");
      chk(32'(div_ratio), 32'h30, "new integer");
      @(posedge clk);
      mod_bypass <= 1'b0;
      mod_enable <= 1'b0;
      cycles(3);
      sum_div(4);
      chk(acc, 32'd192, "disabled is integer");
      @(posedge clk);
      ce <= 1'b0;
      wr(5'h03, 24'h000031);
      chk(32'(pending_reg), 32'h0, "frozen write");
      @(posedge clk);
      ce <= 1'b1;
      rd(5'h03, 24'h000030);
      $display("test commit done");
      @(posedge clk);
      rst_b <= 1'b0;
      cycles(2);
      chk(32'(div_ratio), 32'h0, "div in reset");
      @(posedge clk);
      rst_b <= 1'b1;
      rd(5'h04, 24'h000000);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
